/* File: common/sci_pkg.sv */
/*
  Register map, field positions, reset values and codes of the serial channel.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
*/
package sci_pkg;
  localparam logic [7:0] SCI_OFF_CTRL = 8'h00;
  localparam logic [7:0] SCI_OFF_TXDATA = 8'h04;
  localparam logic [7:0] SCI_OFF_RXDATA = 8'h08;
  localparam logic [7:0] SCI_OFF_STATUS = 8'h0c;
  localparam logic [7:0] SCI_OFF_DIV = 8'h10;
  localparam logic [7:0] SCI_OFF_SOFT_RESET_FIELD = 8'h14;
  // Control fields
  localparam int SCI_C_UART = 0;
  localparam int SCI_C_RXE = 1;
  localparam int SCI_C_TXE = 2;
  localparam int SCI_C_DRIVE = 3;
  localparam int SCI_C_EDGE = 4;
  localparam int SCI_C_DBL = 5;
  localparam int SCI_C_PE = 6;
  localparam int SCI_C_EVEN = 7;
  localparam int SCI_C_FIFO = 8;
  localparam int SCI_C_TFIS = 9;
  localparam int SCI_C_TIL = 10;
  localparam int SCI_CTRL_W = 12;
  localparam logic [11:0] SCI_CTRL_RST = 12'h000;
  // Status fields
  localparam int SCI_S_TX_BUFFER_EMPTY_FLAG = 0;
  localparam int SCI_S_RBFULL = 1;
  localparam int SCI_S_TX_RUNNING_FLAG = 2;
  localparam int SCI_S_OVERRUN_ERROR_FLAG = 3;
  localparam int SCI_S_PARITY_UNDERRUN_ERROR_FLAG = 4;
  localparam int SCI_S_FRAMING_ERROR_FLAG = 5;
  localparam int SCI_S_TLVL = 6;
  localparam logic [15:0] SCI_DIV_RST = 16'h0004;
  localparam logic [1:0] SCI_SOFT_RESET_FIELD_1ST = 2'h2;
  localparam logic [1:0] SCI_SOFT_RESET_FIELD_2ND = 2'h1;
  localparam logic [7:0] SCI_DUMMY = 8'hff;
  localparam logic [2:0] SCI_FIFO_FULL = 3'h4;
  localparam logic [3:0] SCI_LAST_BIT = 4'h7;
  localparam logic [3:0] SCI_T_PAR_IDX = 4'h8;
  localparam logic [3:0] SCI_U_PAR_IDX = 4'h9;
  typedef enum logic [2:0] {
    SCI_IDLE = 3'b001,
    SCI_SHIFT = 3'b010,
    SCI_STOP = 3'b100
  } sci_state_t;
endpackage : sci_pkg

/* File: common/sci_pin_if.sv */
/*
  Synchronised pin levels and edges passed from the input stage to the channel.
  Assumes both ends run on pclk.
*/
`timescale 1ns/10ps
interface sci_pin_if;
  logic sclk_rise;
  logic sclk_fall;
  logic rxd_lvl;
  logic rxd_fall;
  modport src(output sclk_rise, output sclk_fall, output rxd_lvl, output rxd_fall);
  modport dst(input sclk_rise, input sclk_fall, input rxd_lvl, input rxd_fall);
endinterface : sci_pin_if

/* File: rtl/sci_sync.sv */
/*
  Three-stage synchronisers with agreement filter for the shift clock and receive data pins.
  Assumes pins are asynchronous to pclk and idle high.
*/
`timescale 1ns/10ps
module sci_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins
  input wire logic sclk_i,
  input wire logic rxd_i,
  // Filtered pin view
  sci_pin_if.src pins
);
  wire [1:0] raw = {rxd_i, sclk_i};
  logic [1:0] lvl_ff;
  logic [1:0] rise_ff;
  logic [1:0] fall_ff;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_pin
      logic [2:0] s_ff;
      wire agree = (s_ff[1] == s_ff[2]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s_ff <= 3'h7;
          lvl_ff[i] <= 1'b1;
          rise_ff[i] <= 1'b0;
          fall_ff[i] <= 1'b0;
        end else begin
          s_ff <= {s_ff[1:0], raw[i]};
          if (agree)
            lvl_ff[i] <= s_ff[1];
          rise_ff[i] <= agree & s_ff[1] & ~lvl_ff[i];
          fall_ff[i] <= agree & ~s_ff[1] & lvl_ff[i];
        end
      end
    end
  endgenerate

  assign pins.sclk_rise = rise_ff[0];
  assign pins.sclk_fall = fall_ff[0];
  assign pins.rxd_lvl = lvl_ff[1];
  assign pins.rxd_fall = fall_ff[1];
endmodule : sci_sync

/* File: rtl/sci_channel.sv */
/*
  Serial channel: APB registers, transmit FIFO and buffers, 8-bit UART and
  synchronous I/O mode with driven or external shift clock.
  Assumes pclk at 20 MHz and pins asynchronous to it.
*/
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module sci_channel (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic rxd_i,
  output logic txd_o,
  // Channel events
  output logic transmit_interrupt,
  output logic receive_interrupt
);
  import sci_pkg::*;

  sci_pin_if pins();

  sci_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sclk_i(sclk_i),
    .rxd_i(rxd_i),
    .pins(pins)
  );

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [11:0] ctrl_ff;
  logic [15:0] div_ff;
  logic [15:0] cnt_ff;
  logic armed_ff;
  sci_state_t st_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] sh_ff;
  logic txd_ff;
  logic used_ff;
  logic par_ff;
  logic ph_ff;
  logic udr_pend_ff;
  logic sclk_ff;
  logic sclk_oe_ff;
  logic [7:0] tbuf_ff;
  logic tbuf_v_ff;
  logic [7:0] tsh_ff;
  logic tsh_v_ff;
  logic tx_buffer_empty_flag_ff;
  logic [7:0] mem_ff [4];
  logic [1:0] wp_ff;
  logic [1:0] rp_ff;
  logic [2:0] lvl_ff;
  logic [7:0] rsh_ff;
  logic [7:0] rbuf_ff;
  logic rbfull_ff;
  logic [7:0] rhold_ff;
  logic rhold_v_ff;
  logic ur_act_ff;
  logic ur_ph_ff;
  logic [3:0] ur_cnt_ff;
  logic overrun_error_flag_ff;
  logic parity_underrun_error_flag_ff;
  logic framing_error_flag_ff;
  logic tx_irq_ff;
  logic rx_irq_ff;
  logic [31:0] status_w;

  function automatic logic par_of(input logic [7:0] d, input logic even);
    par_of = even ? ^d : ~^d;
  endfunction : par_of

  // Bus decode
  wire setup = psel & ~penable;
  wire done = psel & penable & pready_ff;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;
  wire hit_ctrl = (paddr == SCI_OFF_CTRL);
  wire hit_tx = (paddr == SCI_OFF_TXDATA);
  wire hit_rx = (paddr == SCI_OFF_RXDATA);
  wire hit_st = (paddr == SCI_OFF_STATUS);
  wire hit_div = (paddr == SCI_OFF_DIV);
  wire hit_sw = (paddr == SCI_OFF_SOFT_RESET_FIELD);
  wire mapped = hit_ctrl | hit_tx | hit_rx | hit_st | hit_div | hit_sw;
  wire srst = wr & hit_sw & armed_ff & (pwdata[1:0] == SCI_SOFT_RESET_FIELD_2ND);
  wire tx_wr = wr & hit_tx;
  wire rx_pop = rd & hit_rx;
  wire st_clr = wr & hit_st;

  // Settings
  wire uart = ctrl_ff[SCI_C_UART];
  wire io = ~uart;
  wire rx_en = ctrl_ff[SCI_C_RXE];
  wire tx_en = ctrl_ff[SCI_C_TXE];
  wire drive = ctrl_ff[SCI_C_DRIVE];
  wire edge_sel = ctrl_ff[SCI_C_EDGE];
  wire dbl = ctrl_ff[SCI_C_DBL];
  wire pe = ctrl_ff[SCI_C_PE];
  wire even = ctrl_ff[SCI_C_EVEN];
  wire fifo_en = ctrl_ff[SCI_C_FIFO];
  wire tfis = ctrl_ff[SCI_C_TFIS];
  wire [1:0] til = ctrl_ff[SCI_C_TIL+:2];

  // Bit-rate tick and shift-clock events
  wire tick = (cnt_ff == 16'h0);
  wire run = (st_ff != SCI_IDLE);
  wire idle_lvl = ~edge_sel;
  wire drv_edge = io & drive & run & tick;
  wire ext_on = io & ~drive & (rx_en | tx_en);
  wire ext_act = edge_sel ? pins.sclk_fall : pins.sclk_rise;
  wire ext_inact = edge_sel ? pins.sclk_rise : pins.sclk_fall;
  wire act = drive ? drv_edge & (sclk_ff != idle_lvl) : ext_on & ext_act;
  wire inact = drive ? drv_edge & (sclk_ff == idle_lvl) : ext_on & ext_inact;
  wire first = (bitcnt_ff == 4'h0);
  wire frame_end = act & (bitcnt_ff == SCI_LAST_BIT);

  // Transmit data paths
  wire tx_have = dbl ? tsh_v_ff : tbuf_v_ff;
  wire [7:0] tx_word = dbl ? tsh_ff : tbuf_ff;
  wire tx_real = tx_en & tx_have;
  wire [7:0] load_byte = tx_real ? tx_word : SCI_DUMMY;
  wire rx_dbl = dbl | ~drive;
  wire rx_room = rx_dbl ? ~rhold_v_ff : ~rbfull_ff;
  // Driven clock starts only when every enabled direction can proceed
  wire drv_go = io & drive & ~run & (tx_en | rx_en) & (~tx_en | tx_have) & (~rx_en | rx_room);
  wire io_load = inact & first;
  wire u_go = uart & ~run & tx_en & tx_have;
  wire utick = tick & ph_ff;
  wire [3:0] t_stop = SCI_T_PAR_IDX + {3'h0, pe};
  wire u_pre_stop = uart & (st_ff == SCI_SHIFT) & utick & (bitcnt_ff == t_stop);
  wire u_end = uart & (st_ff == SCI_STOP) & utick;
  wire single_take = ~dbl & ((io_load & tx_real) | u_go);
  wire dbl_move = dbl & tbuf_v_ff & ~tsh_v_ff;
  wire tsh_done = dbl & used_ff & ((io & frame_end) | u_end);
  wire udr = io_load & tx_en & ~tx_have & ~drive;

  // FIFO
  wire f_push = tx_wr & fifo_en & (lvl_ff != SCI_FIFO_FULL);
  wire f_pop = fifo_en & (lvl_ff != 3'h0) & ~tbuf_v_ff;
  wire [2:0] lvl_next = lvl_ff + {2'h0, f_push} - {2'h0, f_pop};
  wire [2:0] til_w = {1'b0, til};
  wire fifo_irq = fifo_en & ((f_pop & ~tfis & (lvl_next == til_w))
                  | (tfis & (f_pop | f_push) & (lvl_next <= til_w)));
  wire buf_irq = ~fifo_en & ((dbl & dbl_move)
                 | (~dbl & ((io & frame_end & used_ff) | u_pre_stop)));

  // Receive paths
  wire [7:0] rx_next = {pins.rxd_lvl, rsh_ff[7:1]};
  wire rb_busy = rbfull_ff & ~(rx_pop & ~rhold_v_ff);
  wire io_rx_end = io & frame_end & rx_en;
  wire ur_smp = ur_act_ff & tick & ur_ph_ff;
  wire [3:0] u_stop = SCI_U_PAR_IDX + {3'h0, pe};
  wire ur_data = ur_smp & (ur_cnt_ff != 4'h0) & (ur_cnt_ff < SCI_U_PAR_IDX);
  wire ur_end = ur_smp & (ur_cnt_ff == u_stop);
  wire ur_parity_underrun_error_flag = ur_smp & pe & (ur_cnt_ff == SCI_U_PAR_IDX)
                 & (pins.rxd_lvl != par_of(rsh_ff, even));
  wire ovr = (io_rx_end & ~drive & rb_busy & rhold_v_ff) | (ur_end & rb_busy);
  wire udr_set = act & first & udr_pend_ff;
  wire rx_irq = ((io_rx_end | ur_end) & ~rb_busy) | (rx_pop & rhold_v_ff);

  always_comb begin
    status_w = 32'h0;
    status_w[SCI_S_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag_ff;
    status_w[SCI_S_RBFULL] = rbfull_ff;
    status_w[SCI_S_TX_RUNNING_FLAG] = run;
    status_w[SCI_S_OVERRUN_ERROR_FLAG] = overrun_error_flag_ff;
    status_w[SCI_S_PARITY_UNDERRUN_ERROR_FLAG] = parity_underrun_error_flag_ff;
    status_w[SCI_S_FRAMING_ERROR_FLAG] = framing_error_flag_ff;
    status_w[SCI_S_TLVL+:3] = lvl_ff;
  end

  wire [31:0] rd_mux = hit_ctrl ? {20'h0, ctrl_ff} :
                       hit_rx ? {24'h0, rbuf_ff} :
                       hit_st ? status_w :
                       hit_div ? {16'h0, div_ff} : 32'h0;

  // No wait state: ready in the first access cycle, read data from a flip-flop loaded in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup)
        prdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= SCI_CTRL_RST;
    end else if (wr & hit_ctrl) begin
      ctrl_ff <= pwdata[SCI_CTRL_W-1:0];
    end else if (srst) begin
      ctrl_ff[SCI_C_RXE] <= 1'b0;
      ctrl_ff[SCI_C_TXE] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= SCI_DIV_RST;
      armed_ff <= 1'b0;
    end else begin
      if (wr & hit_div)
        div_ff <= pwdata[15:0];
      if (wr & hit_sw)
        armed_ff <= (pwdata[1:0] == SCI_SOFT_RESET_FIELD_1ST);
    end
  end

  // Half-bit tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_ff <= 16'h0;
    else if (tick)
      cnt_ff <= div_ff;
    else
      cnt_ff <= cnt_ff - 16'h1;
  end

  // Transmit engine shared by both modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= SCI_IDLE;
      bitcnt_ff <= 4'h0;
      sh_ff <= 8'h0;
      txd_ff <= 1'b1;
      used_ff <= 1'b0;
      par_ff <= 1'b0;
      udr_pend_ff <= 1'b0;
    end else if (srst) begin
      st_ff <= SCI_IDLE;
      bitcnt_ff <= 4'h0;
      txd_ff <= 1'b1;
      used_ff <= 1'b0;
      udr_pend_ff <= 1'b0;
    end else if (io) begin
      if (drv_go)
        st_ff <= SCI_SHIFT;
      if (io_load) begin
        st_ff <= SCI_SHIFT;
        txd_ff <= load_byte[0];
        sh_ff <= {1'b1, load_byte[7:1]};
        used_ff <= tx_real;
        udr_pend_ff <= udr;
      end else if (inact) begin
        txd_ff <= sh_ff[0];
        sh_ff <= {1'b1, sh_ff[7:1]};
      end
      if (act)
        bitcnt_ff <= bitcnt_ff + 4'h1;
      if (act & first)
        udr_pend_ff <= 1'b0;
      if (frame_end) begin
        st_ff <= SCI_IDLE;
        bitcnt_ff <= 4'h0;
        used_ff <= 1'b0;
      end
    end else begin
      case (st_ff)
        SCI_IDLE: begin
          if (u_go) begin
            st_ff <= SCI_SHIFT;
            txd_ff <= 1'b0;
            sh_ff <= tx_word;
            par_ff <= par_of(tx_word, even);
            bitcnt_ff <= 4'h0;
            used_ff <= 1'b1;
          end
        end
        SCI_SHIFT: begin
          if (utick) begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
            if (bitcnt_ff < SCI_T_PAR_IDX) begin
              txd_ff <= sh_ff[0];
              sh_ff <= {1'b1, sh_ff[7:1]};
            end else if (bitcnt_ff != t_stop) begin
              txd_ff <= par_ff;
            end else begin
              txd_ff <= 1'b1;
              st_ff <= SCI_STOP;
            end
          end
        end
        SCI_STOP: begin
          if (utick) begin
            st_ff <= SCI_IDLE;
            used_ff <= 1'b0;
          end
        end
        default: st_ff <= SCI_IDLE;
      endcase
    end
  end

  // Bit phase: UART bits last two half-bit ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ph_ff <= 1'b0;
    else if (~run | io)
      ph_ff <= 1'b0;
    else if (tick)
      ph_ff <= ~ph_ff;
  end

  // Shift clock rests at its idle level between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_ff <= 1'b1;
      sclk_oe_ff <= 1'b0;
    end else begin
      sclk_oe_ff <= io & drive;
      if (srst | ~run)
        sclk_ff <= idle_lvl;
      else if (drv_edge)
        sclk_ff <= ~sclk_ff;
    end
  end

  // Transmit buffer, shift staging and empty flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbuf_ff <= 8'h0;
      tbuf_v_ff <= 1'b0;
      tsh_ff <= 8'h0;
      tsh_v_ff <= 1'b0;
      tx_buffer_empty_flag_ff <= 1'b0;
    end else if (srst) begin
      tbuf_v_ff <= 1'b0;
      tsh_v_ff <= 1'b0;
      tx_buffer_empty_flag_ff <= 1'b0;
    end else begin
      if (single_take | dbl_move)
        tbuf_v_ff <= 1'b0;
      if (tx_wr & ~fifo_en) begin
        tbuf_ff <= pwdata[7:0];
        tbuf_v_ff <= 1'b1;
      end else if (f_pop) begin
        tbuf_ff <= mem_ff[rp_ff];
        tbuf_v_ff <= 1'b1;
      end
      if (dbl_move) begin
        tsh_ff <= tbuf_ff;
        tsh_v_ff <= 1'b1;
      end else if (tsh_done) begin
        tsh_v_ff <= 1'b0;
      end
      if (dbl_move)
        tx_buffer_empty_flag_ff <= 1'b1;
      else if (tx_wr)
        tx_buffer_empty_flag_ff <= 1'b0;
    end
  end

  // Transmit FIFO storage and pointers
  always_ff @(posedge pclk) begin
    if (f_push)
      mem_ff[wp_ff] <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_ff <= 2'h0;
      rp_ff <= 2'h0;
      lvl_ff <= 3'h0;
    end else if (srst) begin
      wp_ff <= 2'h0;
      rp_ff <= 2'h0;
      lvl_ff <= 3'h0;
    end else begin
      if (f_push)
        wp_ff <= wp_ff + 2'h1;
      if (f_pop)
        rp_ff <= rp_ff + 2'h1;
      lvl_ff <= lvl_next;
    end
  end

  // Receive shift register, shared by both modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rsh_ff <= 8'h0;
    else if ((io & act) | ur_data)
      rsh_ff <= rx_next;
  end

  // UART receiver: samples at mid-bit after start edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ur_act_ff <= 1'b0;
      ur_ph_ff <= 1'b0;
      ur_cnt_ff <= 4'h0;
    end else if (srst) begin
      ur_act_ff <= 1'b0;
    end else if (uart & rx_en & ~ur_act_ff & pins.rxd_fall) begin
      ur_act_ff <= 1'b1;
      ur_ph_ff <= 1'b1;
      ur_cnt_ff <= 4'h0;
    end else if (ur_act_ff & tick) begin
      ur_ph_ff <= ~ur_ph_ff;
      if (ur_ph_ff) begin
        ur_cnt_ff <= ur_cnt_ff + 4'h1;
        // A start bit that is high again was a glitch
        if (((ur_cnt_ff == 4'h0) & pins.rxd_lvl) | (ur_cnt_ff == u_stop))
          ur_act_ff <= 1'b0;
      end
    end
  end

  // Receive buffer with hold stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbuf_ff <= 8'h0;
      rbfull_ff <= 1'b0;
      rhold_ff <= 8'h0;
      rhold_v_ff <= 1'b0;
    end else if (srst) begin
      rbfull_ff <= 1'b0;
      rhold_v_ff <= 1'b0;
    end else begin
      if (rx_pop) begin
        if (rhold_v_ff) begin
          rbuf_ff <= rhold_ff;
          rhold_v_ff <= 1'b0;
        end else begin
          rbfull_ff <= 1'b0;
        end
      end
      if ((io_rx_end | ur_end) & ~rb_busy) begin
        rbuf_ff <= ur_end ? rsh_ff : rx_next;
        rbfull_ff <= 1'b1;
      end else if (io_rx_end & rx_dbl & ~rhold_v_ff) begin
        rhold_ff <= rx_next;
        rhold_v_ff <= 1'b1;
      end
    end
  end

  // Error flags: hardware set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag_ff <= 1'b0;
      parity_underrun_error_flag_ff <= 1'b0;
      framing_error_flag_ff <= 1'b0;
    end else if (srst) begin
      overrun_error_flag_ff <= 1'b0;
      parity_underrun_error_flag_ff <= 1'b0;
      framing_error_flag_ff <= 1'b0;
    end else begin
      if (ovr)
        overrun_error_flag_ff <= 1'b1;
      else if (st_clr & pwdata[SCI_S_OVERRUN_ERROR_FLAG])
        overrun_error_flag_ff <= 1'b0;
      if (ur_parity_underrun_error_flag | udr_set)
        parity_underrun_error_flag_ff <= 1'b1;
      else if (st_clr & pwdata[SCI_S_PARITY_UNDERRUN_ERROR_FLAG])
        parity_underrun_error_flag_ff <= 1'b0;
      if (ur_end & ~pins.rxd_lvl)
        framing_error_flag_ff <= 1'b1;
      else if (st_clr & pwdata[SCI_S_FRAMING_ERROR_FLAG])
        framing_error_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= ~srst & (fifo_irq | buf_irq);
      rx_irq_ff <= ~srst & rx_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sclk_o = sclk_ff;
  assign sclk_oe = sclk_oe_ff;
  assign txd_o = txd_ff;
  assign transmit_interrupt = tx_irq_ff;
  assign receive_interrupt = rx_irq_ff;
endmodule : sci_channel

/* File: test/sci_channel_assertions.sv */
/* Port checker for the serial channel: bus timing, event pulses, soft reset.
   Assumes it is bound to the channel's top module. */
`timescale 1ns/10ps
module sci_channel_assertions (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic sclk_i,
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic rxd_i,
  input wire logic txd_o,
  input wire logic transmit_interrupt,
  input wire logic receive_interrupt
);
  import sci_pkg::*;
  logic armed_ff;
  logic nxt_armed;
  logic swr_acc;
  logic ctrl_acc;
  logic soft_go;
  assign swr_acc = psel && penable && pready && pwrite && (paddr == SCI_OFF_SOFT_RESET_FIELD);
  assign ctrl_acc = psel && penable && pready && pwrite && (paddr == SCI_OFF_CTRL);
  assign soft_go = swr_acc && armed_ff && (pwdata[1:0] == SCI_SOFT_RESET_FIELD_2ND);
  // Any other value written to the field disarms
  assign nxt_armed = swr_acc ? (pwdata[1:0] == SCI_SOFT_RESET_FIELD_1ST) : armed_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= nxt_armed;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_setup_a: assert property (psel && !penable |=> pready) else $error("no pready");
  pready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
  pready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  slverr_ready_a: assert property (pslverr |-> pready) else $error("stray pslverr");
  unmapped_err_a: assert property (psel && !penable && (paddr > SCI_OFF_SOFT_RESET_FIELD) |=> pslverr)
    else $error("unmapped accepted");
  mapped_ok_a: assert property (psel && !penable && (paddr == SCI_OFF_CTRL) |=> !pslverr)
    else $error("mapped refused");
  tx_pulse_a: assert property (transmit_interrupt |=> !transmit_interrupt) else $error("tx event long");
  rx_pulse_a: assert property (receive_interrupt |=> !receive_interrupt) else $error("rx event long");
  soft_reset_field_quiet_a: assert property (soft_go |=> ##1 (txd_o && !transmit_interrupt)[*3])
    else $error("channel active after soft reset");
  clk_drive_a: assert property ($changed(sclk_oe) |-> $past(ctrl_acc) || $past(ctrl_acc, 2))
    else $error("clock drive changed alone");
  cover property (transmit_interrupt);
  cover property (receive_interrupt);
  cover property (soft_go);
endmodule : sci_channel_assertions

bind sci_channel sci_channel_assertions sci_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .sclk_i, .sclk_o, .sclk_oe, .rxd_i, .txd_o, .transmit_interrupt,
  .receive_interrupt);

/* File: test/sci_peer.sv */
/* Serial peer on the shift clock and data pins.
   Assumes rising edge active, clock idle high. */
`timescale 1ns/10ps
module sci_peer (
  // Device side
  input wire logic sclk_o,
  input wire logic sclk_oe,
  input wire logic txd_o,
  // Peer side
  output logic sclk_i,
  output logic rxd_i
);
  logic [7:0] got = 8'h00;
  initial begin
    sclk_i = 1'b1;
    rxd_i = 1'b1;
  end
  always @(posedge sclk_o) begin
    if (sclk_oe) begin
      got <= {txd_o, got[7:1]};
    end
  end
  // Clock stands high between frames; txd read late as the device sees edges through synchronisers
  task automatic frame(input logic [7:0] b);
    #5;
    for (int i = 0; i < 8; i++) begin
      sclk_i = 1'b0;
      rxd_i = b[i];
      #200;
      sclk_i = 1'b1;
      #190;
      got = {txd_o, got[7:1]};
      #10;
    end
    rxd_i = 1'b1; // Pulled high once released
  endtask : frame
endmodule : sci_peer

/* File: test/test_serial_channel_sync_io_events.sv */
/* Bench for the serial channel: registers, driven and external clock transfers, soft reset.
   Assumes the peer model and the bound checker. */
`timescale 1ns/10ps
module test_serial_channel_sync_io_events;
  import sci_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, txd_q;
  logic [1:0] tx_edge;
  logic sclk_i, sclk_o, sclk_oe, rxd_i, txd_o, transmit_interrupt, receive_interrupt;
  logic [7:0] paddr, b0, b1;
  logic [31:0] pwdata, prdata, r;
  int error_cnt = 0;
  int comparisons = 0;
  int tx_n = 0;
  int rx_n = 0;
  int t, u;
  integer seed = 32'h936918ce;
  sci_channel sci_channel_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sclk_i, .sclk_o, .sclk_oe, .rxd_i, .txd_o, .transmit_interrupt, .receive_interrupt);
  sci_peer sci_peer_inst (.sclk_o, .sclk_oe, .txd_o, .sclk_i, .rxd_i);
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    tx_n <= tx_n + transmit_interrupt;
    rx_n <= rx_n + receive_interrupt;
    // Line level just before and at each transmit event
    txd_q <= txd_o;
    if (transmit_interrupt)
      tx_edge <= {txd_q, txd_o};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_tx();
    for (int i = 0; i < 400 && tx_n == t; i++) @(posedge pclk);
  endtask : wait_tx
  task automatic summarize();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    summarize();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SCI_OFF_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, SCI_OFF_DIV, 32'h0);
    chk(r, {16'h0, SCI_DIV_RST});
    apb(1'b0, 8'h18, 32'h0);
    chk(e, 1'b1);
    u = ($random(seed) & 3) + 1;
    apb(1'b1, SCI_OFF_DIV, u);
    apb(1'b0, SCI_OFF_DIV, 32'h0);
    chk(r, u);
    apb(1'b1, SCI_OFF_CTRL, 32'h00c);
    for (int k = 0; k < 3; k++) begin
      b0 = (k == 0) ? 8'h80 : 8'($random(seed));
      t = tx_n;
      apb(1'b1, SCI_OFF_TXDATA, {24'h0, b0});
      wait_tx();
      @(posedge pclk);
      chk(sci_peer_inst.got, b0);
      chk(tx_n - t, 1);
    end
    // Second byte goes in while the first is still shifting
    b1 = 8'($random(seed));
    apb(1'b1, SCI_OFF_CTRL, 32'h02c);
    t = tx_n;
    apb(1'b1, SCI_OFF_TXDATA, {24'h0, b0});
    wait_tx();
    apb(1'b0, SCI_OFF_STATUS, 32'h0);
    chk(r[SCI_S_TX_BUFFER_EMPTY_FLAG], 1'b1);
    t = tx_n;
    apb(1'b1, SCI_OFF_TXDATA, {24'h0, b1});
    wait_tx();
    repeat (200) @(posedge pclk);
    chk(tx_n - t, 1);
    chk(sci_peer_inst.got, b1);
    chk(sclk_o, 1'b1);
    chk(sclk_oe, 1'b1);
    apb(1'b0, SCI_OFF_STATUS, 32'h0);
    chk(r[4:3], 2'h0);
    apb(1'b1, SCI_OFF_CTRL, 32'h006);
    t = tx_n;
    u = rx_n;
    apb(1'b1, SCI_OFF_TXDATA, {24'h0, b0});
    sci_peer_inst.frame(b1);
    repeat (20) @(posedge pclk);
    chk(sci_peer_inst.got, b0);
    chk(tx_n - t, 1);
    chk(rx_n - u, 1);
    apb(1'b0, SCI_OFF_RXDATA, 32'h0);
    chk(r[7:0], b1);
    sci_peer_inst.frame(b0);
    repeat (20) @(posedge pclk);
    chk(sci_peer_inst.got, SCI_DUMMY);
    apb(1'b0, SCI_OFF_STATUS, 32'h0);
    chk(r[SCI_S_PARITY_UNDERRUN_ERROR_FLAG], 1'b1);
    apb(1'b0, SCI_OFF_RXDATA, 32'h0);
    chk(r[7:0], b0);
    apb(1'b1, SCI_OFF_CTRL, 32'h046);
    apb(1'b1, SCI_OFF_SOFT_RESET_FIELD, 32'h2);
    apb(1'b1, SCI_OFF_SOFT_RESET_FIELD, 32'h0);
    apb(1'b1, SCI_OFF_SOFT_RESET_FIELD, 32'h1);
    apb(1'b0, SCI_OFF_STATUS, 32'h0);
    chk(r[SCI_S_PARITY_UNDERRUN_ERROR_FLAG], 1'b1);
    apb(1'b1, SCI_OFF_SOFT_RESET_FIELD, 32'h2);
    apb(1'b1, SCI_OFF_SOFT_RESET_FIELD, 32'h1);
    apb(1'b0, SCI_OFF_STATUS, 32'h0);
    chk(r[8:0], 9'h0);
    apb(1'b0, SCI_OFF_CTRL, 32'h0);
    chk(r, 32'h040);
    // All-zero byte: the line rises to the stop bit with the event
    apb(1'b1, SCI_OFF_CTRL, 32'h005);
    t = tx_n;
    apb(1'b1, SCI_OFF_TXDATA, 32'h0);
    wait_tx();
    chk(tx_n - t, 1);
    chk(tx_edge, 2'b01);
    repeat (40) @(posedge pclk);
    // Threshold 0 gives one event on the move, threshold 1 none
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, SCI_OFF_CTRL, k ? 32'h50c : 32'h10c);
      t = tx_n;
      apb(1'b1, SCI_OFF_TXDATA, {24'h0, b1});
      repeat (200) @(posedge pclk);
      chk(tx_n - t, 1 - k);
      chk(sci_peer_inst.got, b1);
    end
    summarize();
  end
endmodule : test_serial_channel_sync_io_events
